// >>> verilog/bls_defs.svh
// Constants of the bus byte-lane steering block
`ifndef BLS_DEFS_SVH
`define BLS_DEFS_SVH
// Bus cycle status codes driven during the address and command phases
`define BLS_ST_INTERRUPT_ACKNOWLEDGE_CYCLE 3'h0
`define BLS_ST_IO_RD 3'h1
`define BLS_ST_IO_WR 3'h2
`define BLS_ST_PREFETCH 3'h4
`define BLS_ST_MEM_RD 3'h5
`define BLS_ST_MEM_WR 3'h6
`define BLS_ST_PASSIVE 3'h7
// Upper address nibble forced on I/O cycles
`define BLS_IO_HI 4'h0
// Byte counts of a transfer
`define BLS_N_BYTE 3'h1
`define BLS_N_WORD 3'h2
`define BLS_N_VECTOR 3'h4
// Inactive level of active-low strobes, used at reset
`define BLS_STROBE_OFF 1'b1
`endif

// >>> verilog/bls_pkg.sv
// Types of the bus byte-lane steering block
package bls_pkg;
   typedef enum logic [2:0] {
      BLS_K_MEM_RD, BLS_K_MEM_WR, BLS_K_IO_RD, BLS_K_IO_WR,
      BLS_K_PREFETCH, BLS_K_INTERRUPT_ACKNOWLEDGE_CYCLE, BLS_K_VECTOR
   } bls_kind_type;
   typedef enum logic [2:0] {
      BLS_S_IDLE, BLS_S_ADR, BLS_S_CMD, BLS_S_HOLD, BLS_S_DONE
   } bls_phase_type;
   typedef struct packed {
      bls_kind_type kind;
      logic [19:0] addr;
      logic is_word;
      logic [15:0] wdata;
   } bls_req_type;
   typedef struct packed {
      logic [15:0] ad_out;
      logic ad_oe;
      logic [3:0] a_hi;
      logic ale;
      logic [2:0] status;
      logic rd_n;
      logic wr_n;
      logic upper_byte_enable_n;
   } bls_bus_type;
   typedef struct packed {
      bls_phase_type st;
      bls_kind_type kind;
      logic mode8;
      logic [19:0] addr;
      logic [2:0] left;
      logic [1:0] idx;
      logic cyc_word;
      logic [15:0] wdat;
      logic [31:0] acc;
      logic req_ready;
      logic rsp_valid;
      logic [31:0] rsp_data;
      bls_bus_type bus;
      logic [15:0] d_s1;
      logic [15:0] d_s2;
      logic mode_s1;
      logic mode_s2;
   } bls_state_type;
endpackage : bls_pkg

// >>> verilog/bls_bus_interface_unit.sv
// Byte-lane steering and access splitting of the external bus
// Notes on behaviour
// - Memory space 1 Mbyte, I/O space 64 Kbytes, words are two bytes.
// - Wide bus: even bytes on the low lane, odd bytes on the high lane.
// - Wide bus: address 19..1 picks the word, bit 0 and enable pick banks.
// - Even byte: bit 0 low, upper enable high, high lane ignored on read.
// - Odd byte: upper enable low, bit 0 high, low lane ignored on read.
// - Even word: one cycle on both lanes, bit 0 and enable low.
// - Odd word: upper-lane byte at odd address, then low-lane byte next.
// - Byte reads leave all sixteen data lines undriven.
// - Byte writes drive both lanes; the unused lane value is undefined.
// - Narrow bus: one bank, address 19..0, all data on one lane.
// - Narrow bus: every word is two byte cycles, address then plus one.
// - I/O cycles drive address 19..16 to zero.
// - Interrupt acknowledge: no valid address, data on low lane only.
// - Interrupt fetches two even words from region 0H to 3FFH.
// - Cycle starts with address and status, then read or write strobe.
// - Cycle end captures read data or stops driving write data.
`timescale 1ns/10ps
`default_nettype none
`include "bls_defs.svh"
module bls_bus_interface_unit (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic bus_8bit,
   input wire logic req_valid,
   input wire bls_pkg::bls_req_type req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [31:0] rsp_data,
   input wire logic [15:0] ad_in,
   output bls_pkg::bls_bus_type bus
);
   bls_pkg::bls_state_type r;
   bls_pkg::bls_state_type n;
   logic accept;

   function automatic logic is_write(bls_pkg::bls_kind_type k);
      return k == bls_pkg::BLS_K_MEM_WR || k == bls_pkg::BLS_K_IO_WR;
   endfunction : is_write

   function automatic logic [2:0] status_of(bls_pkg::bls_kind_type k);
      logic [2:0] s;
      s = `BLS_ST_MEM_RD;
      unique case (k)
         bls_pkg::BLS_K_MEM_RD: s = `BLS_ST_MEM_RD;
         bls_pkg::BLS_K_MEM_WR: s = `BLS_ST_MEM_WR;
         bls_pkg::BLS_K_IO_RD: s = `BLS_ST_IO_RD;
         bls_pkg::BLS_K_IO_WR: s = `BLS_ST_IO_WR;
         bls_pkg::BLS_K_PREFETCH: s = `BLS_ST_PREFETCH;
         bls_pkg::BLS_K_INTERRUPT_ACKNOWLEDGE_CYCLE: s = `BLS_ST_INTERRUPT_ACKNOWLEDGE_CYCLE;
         bls_pkg::BLS_K_VECTOR: s = `BLS_ST_MEM_RD;
         default: s = `BLS_ST_PASSIVE;
      endcase
      return s;
   endfunction : status_of

   // Address phase of the next bus cycle of the current transfer
   function automatic bls_pkg::bls_state_type start_cycle(
      bls_pkg::bls_state_type s);
      logic w;
      logic interrupt_acknowledge_cycle;
      interrupt_acknowledge_cycle = s.kind == bls_pkg::BLS_K_INTERRUPT_ACKNOWLEDGE_CYCLE;
      // Only an even pair on the wide bus fits one cycle
      w = s.left >= `BLS_N_WORD && !s.mode8 && !s.addr[0];
      s.cyc_word = w;
      s.st = bls_pkg::BLS_S_ADR;
      s.bus.ale = 1'b1;
      s.bus.status = status_of(s.kind);
      s.bus.rd_n = `BLS_STROBE_OFF;
      s.bus.wr_n = `BLS_STROBE_OFF;
      s.bus.ad_out = s.addr[15:0];
      s.bus.a_hi = s.addr[19:16];
      // No valid address on acknowledge, so the pins float
      s.bus.ad_oe = !interrupt_acknowledge_cycle;
      // Upper bank joins only for odd bytes or even words
      s.bus.upper_byte_enable_n = s.mode8 || interrupt_acknowledge_cycle || !(w || s.addr[0]);
      return s;
   endfunction : start_cycle

   assign accept = req_valid && r.req_ready;

   always_comb begin
      logic [7:0] lo_b;
      logic [15:0] d;
      logic [2:0] step;
      lo_b = 8'h00;
      d = 16'h0000;
      step = 3'h0;
      n = r;
      n.rsp_valid = 1'b0;
      n.d_s1 = ad_in;
      n.d_s2 = r.d_s1;
      n.mode_s1 = bus_8bit;
      n.mode_s2 = r.mode_s1;
      unique case (r.st)
         bls_pkg::BLS_S_IDLE: begin
            n.req_ready = 1'b1;
            if (accept) begin
               n.req_ready = 1'b0;
               n.kind = req.kind;
               n.mode8 = r.mode_s2;
               n.addr = req.addr;
               n.left = req.is_word ? `BLS_N_WORD : `BLS_N_BYTE;
               if (req.kind == bls_pkg::BLS_K_PREFETCH) begin
                  n.left = `BLS_N_WORD;
               end
               if (req.kind == bls_pkg::BLS_K_INTERRUPT_ACKNOWLEDGE_CYCLE) begin
                  n.addr = 20'h00000;
                  n.left = `BLS_N_BYTE;
               end
               if (req.kind == bls_pkg::BLS_K_VECTOR) begin
                  // Type number times four stays below 400H
                  n.addr = {10'h000, req.addr[7:0], 2'b00};
                  n.left = `BLS_N_VECTOR;
               end
               if (req.kind == bls_pkg::BLS_K_IO_RD ||
                   req.kind == bls_pkg::BLS_K_IO_WR) begin
                  n.addr[19:16] = `BLS_IO_HI;
               end
               n.idx = 2'h0;
               n.wdat = req.wdata;
               n.acc = 32'h00000000;
               n = start_cycle(n);
            end
         end
         bls_pkg::BLS_S_ADR: begin
            n.bus.ale = 1'b0;
            n.st = bls_pkg::BLS_S_CMD;
            if (is_write(r.kind)) begin
               n.bus.wr_n = 1'b0;
               n.bus.ad_oe = 1'b1;
               // Byte copied to both lanes; the idle lane is don't-care
               n.bus.ad_out = r.cyc_word ? r.wdat : {2{r.wdat[7:0]}};
            end else begin
               n.bus.rd_n = 1'b0;
               n.bus.ad_oe = 1'b0;
            end
         end
         bls_pkg::BLS_S_CMD: begin
            n.st = bls_pkg::BLS_S_HOLD;
         end
         bls_pkg::BLS_S_HOLD: begin
            n.st = bls_pkg::BLS_S_DONE;
            n.bus.status = `BLS_ST_PASSIVE;
         end
         bls_pkg::BLS_S_DONE: begin
            n.bus.rd_n = `BLS_STROBE_OFF;
            n.bus.wr_n = `BLS_STROBE_OFF;
            n.bus.ad_oe = 1'b0;
            d = r.d_s2;
            // Lane choice follows address bit 0 on the wide bus
            lo_b = (r.mode8 || !r.addr[0] ||
                    r.kind == bls_pkg::BLS_K_INTERRUPT_ACKNOWLEDGE_CYCLE) ? d[7:0] : d[15:8];
            if (!is_write(r.kind)) begin
               if (r.cyc_word) begin
                  n.acc[{r.idx, 3'b000} +: 8] = d[7:0];
                  n.acc[{2'(r.idx + 2'h1), 3'b000} +: 8] = d[15:8];
               end else begin
                  n.acc[{r.idx, 3'b000} +: 8] = lo_b;
               end
            end
            step = r.cyc_word ? `BLS_N_WORD : `BLS_N_BYTE;
            n.left = r.left - step;
            n.addr = r.addr + 20'(step);
            n.idx = r.idx + step[1:0];
            n.wdat = r.cyc_word ? 16'h0000 : {8'h00, r.wdat[15:8]};
            if (n.left == 3'h0) begin
               n.rsp_valid = 1'b1;
               n.rsp_data = n.acc;
               n.st = bls_pkg::BLS_S_IDLE;
               n.req_ready = 1'b1;
            end else begin
               n = start_cycle(n);
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.bus.status <= `BLS_ST_PASSIVE;
         r.bus.rd_n <= `BLS_STROBE_OFF;
         r.bus.wr_n <= `BLS_STROBE_OFF;
         r.bus.upper_byte_enable_n <= `BLS_STROBE_OFF;
      end else begin
         r <= n;
      end
   end

   assign req_ready = r.req_ready;
   assign rsp_valid = r.rsp_valid;
   assign rsp_data = r.rsp_data;
   assign bus = r.bus;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_cmd;
      !r.bus.ale && (!r.bus.rd_n || !r.bus.wr_n);
   endsequence
   // A split transfer may open its next address phase at once
   sequence s_release;
      r.bus.rd_n && r.bus.wr_n && (!r.bus.ad_oe || r.bus.ale);
   endsequence

   AST_CYCLE_ORDER: assert property (
      r.bus.ale && r.bus.status != `BLS_ST_PASSIVE |->
      ##1 s_cmd ##1 s_cmd ##1 s_cmd ##1 s_release)
      else $error("bus cycle phases out of order");
   AST_IO_UPPER_ZERO: assert property (
      r.bus.ale && (r.bus.status == `BLS_ST_IO_RD ||
      r.bus.status == `BLS_ST_IO_WR) |-> r.bus.a_hi == `BLS_IO_HI)
      else $error("I/O cycle upper address not zero");
   AST_INTERRUPT_ACKNOWLEDGE_CYCLE_NO_ADDR: assert property (
      r.bus.ale && r.bus.status == `BLS_ST_INTERRUPT_ACKNOWLEDGE_CYCLE |->
      !r.bus.ad_oe && r.bus.upper_byte_enable_n)
      else $error("acknowledge cycle drives address or upper lane");
   AST_READ_FLOATS: assert property (
      !r.bus.rd_n |-> !r.bus.ad_oe && r.bus.wr_n)
      else $error("data driven during a read");
   AST_WRITE_DRIVES: assert property (
      $fell(r.bus.wr_n) |-> r.bus.ad_oe [*3] ##1 (!r.bus.ad_oe || r.bus.ale))
      else $error("write data not held to cycle end");
   AST_NARROW_NO_UBE: assert property (
      r.bus.ale && r.mode8 |-> r.bus.upper_byte_enable_n)
      else $error("upper enable on narrow bus");
   AST_EVEN_WORD: assert property (
      r.bus.ale && r.cyc_word |->
      !r.bus.ad_out[0] && !r.bus.upper_byte_enable_n && !r.mode8)
      else $error("even word enables wrong");
   AST_ODD_BYTE: assert property (
      r.bus.ale && !r.mode8 && r.bus.ad_oe && r.bus.ad_out[0] |->
      !r.bus.upper_byte_enable_n && !r.cyc_word)
      else $error("odd byte enables wrong");
   AST_ODD_WORD_SPLIT: assert property (
      accept && req.is_word && !r.mode_s2 && req.addr[0] &&
      (req.kind == bls_pkg::BLS_K_MEM_RD ||
      req.kind == bls_pkg::BLS_K_MEM_WR) |->
      ##1 (r.bus.ale && r.bus.ad_out[0] && !r.bus.upper_byte_enable_n)
      ##4 (r.bus.ale && !r.bus.ad_out[0] && r.bus.upper_byte_enable_n))
      else $error("odd word not split upper then lower");
   AST_NARROW_WORD_SPLIT: assert property (
      accept && req.is_word && r.mode_s2 &&
      req.kind == bls_pkg::BLS_K_MEM_RD |->
      ##1 r.bus.ale ##4 (r.bus.ale && r.bus.ad_out ==
      16'($past(r.bus.ad_out, 4) + 16'h0001)) ##4 rsp_valid)
      else $error("narrow word not two byte cycles");
   AST_VECTOR_REGION: assert property (
      r.bus.ale && r.kind == bls_pkg::BLS_K_VECTOR |->
      r.bus.a_hi == 4'h0 && r.bus.ad_out[15:10] == 6'h00 &&
      (r.mode8 || !r.bus.ad_out[0]))
      else $error("vector fetch outside region");
endmodule : bls_bus_interface_unit
`default_nettype wire

// >>> verif/bls_mem_model.sv
// Memory and I/O device model on the far side of the bus
`timescale 1ns/10ps
`default_nettype none
module bls_mem_model (
   input wire logic clk,
   input wire logic mode8,
   input wire bls_pkg::bls_bus_type bus,
   output logic [15:0] ad_in
);
   logic [7:0] mem [int];
   logic [19:0] a_q;
   logic [2:0] st_q;
   logic ube_q;
   logic [15:0] last_q = 16'h0;
   function automatic logic [7:0] rb(logic [19:0] a);
      int k;
      k = {11'h0, !st_q[2], a};
      return mem.exists(k) ? mem[k] : a[7:0] ^ a[15:8] ^ {a[19:16], 4'h3};
   endfunction : rb
   always @(posedge clk) begin
      last_q <= ad_in;
      if (bus.ale === 1'b1) begin
         a_q <= {bus.a_hi, bus.ad_out};
         st_q <= bus.status;
         ube_q <= bus.upper_byte_enable_n;
      end
      // A disabled bank keeps its byte
      if (bus.wr_n === 1'b0) begin
         if (mode8 || !a_q[0])
            mem[{11'h0, !st_q[2], a_q}] = bus.ad_out[7:0];
         if (!mode8 && !ube_q)
            mem[{11'h0, !st_q[2], a_q | 20'h1}] = bus.ad_out[15:8];
      end
   end
   // Wide memory drives both lanes; idle lines show a changing pattern
   assign ad_in = (bus.rd_n !== 1'b0) ? ~last_q :
      (st_q == 3'h0) ? {~last_q[15:8], 8'h5A} :
      mode8 ? {~last_q[15:8], rb(a_q)} :
      {rb(a_q | 20'h1), rb(a_q & 20'hFFFFE)};
endmodule : bls_mem_model
`default_nettype wire

// >>> verif/bus_byte_lane_steering_tb.sv
// Self-checking bench for the byte-lane steering block
`timescale 1ns/10ps
`default_nettype none
`include "bls_defs.svh"
module bus_byte_lane_steering_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic bus_8bit = 1'b0;
   logic req_valid = 1'b0;
   bls_pkg::bls_req_type req = '0;
   logic req_ready, rsp_valid;
   logic [31:0] rsp_data;
   logic [15:0] ad_in;
   bls_pkg::bls_bus_type bus;
   logic [31:0] exp_rsp [$];
   logic [21:0] exp_adr [$];
   logic [2:0] exp_st [$];
   logic [7:0] mir [int];
   logic [31:0] seed = 32'h2DB0;
   int err_count = 0;
   int n_compared = 0;
   initial forever #5 clk = ~clk;
   bls_bus_interface_unit u_dut (.clk(clk), .sys_rst(sys_rst),
      .bus_8bit(bus_8bit), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .ad_in(ad_in), .bus(bus));
   bls_mem_model u_mem (.clk(clk), .mode8(bus_8bit), .bus(bus),
      .ad_in(ad_in));
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
      n_compared++;
      if (e !== s) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : cmp
   function automatic logic [7:0] get(logic io, logic [19:0] a);
      int k;
      k = {11'h0, io, a};
      return mir.exists(k) ? mir[k] : a[7:0] ^ a[15:8] ^ {a[19:16], 4'h3};
   endfunction : get
   // Kind index follows the order of the kind enumeration
   task automatic go(int ki, logic [19:0] a, logic w, logic [15:0] d);
      logic [19:0] b, x;
      logic [31:0] e;
      logic io, rd;
      logic [2:0] sv;
      int n, c, m, t;
      io = ki inside {2, 3};
      sv = (ki == 1) ? `BLS_ST_MEM_WR : (ki == 2) ? `BLS_ST_IO_RD :
         (ki == 3) ? `BLS_ST_IO_WR : (ki == 4) ? `BLS_ST_PREFETCH :
         (ki == 5) ? `BLS_ST_INTERRUPT_ACKNOWLEDGE_CYCLE : `BLS_ST_MEM_RD;
      rd = !(ki inside {1, 3});
      b = (ki == 6) ? {10'h0, a[7:0], 2'b00} : a;
      if (io)
         b[19:16] = 4'h0;
      n = (ki == 6) ? 4 : (w || ki == 4) ? 2 : 1;
      e = '0;
      for (c = 0; c < n; c++) begin
         if (rd)
            e[8*c+:8] = get(io, b + c);
         else
            mir[{11'h0, io, 20'(b + c)}] = d[8*c+:8];
      end
      if (ki == 5)
         e = 32'h5A;
      exp_rsp.push_back(e);
      for (c = 0; c < n; c += m) begin
         x = b + c;
         m = (!bus_8bit && !x[0] && n - c > 1) ? 2 : 1;
         exp_adr.push_back({ki == 5, x, bus_8bit || (m == 1 && !x[0])});
         exp_st.push_back(sv);
      end
      @(negedge clk);
      req_valid = 1'b1;
      req = '{bls_pkg::bls_kind_type'(ki), a, w, d};
      t = 0;
      while (req_ready !== 1'b1 && t < 100) begin
         @(negedge clk);
         t++;
      end
      @(negedge clk);
      req_valid = 1'b0;
   endtask : go
   always @(negedge clk) begin
      if (!sys_rst && bus.ale === 1'b1) begin
         if (exp_adr.size() == 0)
            cmp("extra cycle", 0, 1);
         else if (exp_adr[0][21])
            cmp("ack drive", 0, bus.ad_oe);
         else
            cmp("address", exp_adr[0][20:0], {bus.a_hi, bus.ad_out, bus.upper_byte_enable_n});
         if (exp_adr.size() != 0)
            void'(exp_adr.pop_front());
         if (exp_st.size() != 0)
            cmp("status", exp_st.pop_front(), bus.status);
      end
      if (!sys_rst && rsp_valid === 1'b1) begin
         if (exp_rsp.size() == 0)
            cmp("extra response", 0, 1);
         else
            cmp("response", exp_rsp.pop_front(), rsp_data);
      end
      if (bus.rd_n === 1'b0)
         cmp("read float", 0, bus.ad_oe);
      if (bus.wr_n === 1'b0)
         cmp("write drive", 1, bus.ad_oe);
   end
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic done(string nm, logic m8);
      int t;
      t = 0;
      while (exp_rsp.size() != 0 && t < 500) begin
         @(negedge clk);
         t++;
      end
      if (t == 500)
         cmp("drain", 0, 1);
      $display("test %s done", nm);
      bus_8bit = m8;
      repeat (4) @(negedge clk);
   endtask : done
   initial begin
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
      go(0, 20'h12344, 0, 0);
      go(0, 20'h12345, 0, 0);
      go(0, 20'hA0010, 1, 0);
      go(0, 20'hA0013, 1, 0);
      go(1, 20'h30020, 0, 16'h00C3);
      go(1, 20'h30021, 0, 16'h00D4);
      go(1, 20'h30033, 1, 16'hBEEF);
      go(0, 20'h30020, 1, 0);
      go(0, 20'h30032, 1, 0);
      go(0, 20'h30034, 0, 0);
      go(3, 20'hF1234, 1, 16'h5AA5);
      go(2, 20'hF1234, 1, 0);
      go(0, 20'h01234, 1, 0);
      go(4, 20'h00100, 1, 0);
      go(6, 20'h00021, 0, 0);
      go(5, 20'h00000, 0, 0);
      done("wide", 1'b1);
      go(0, 20'h40007, 1, 0);
      go(1, 20'h40010, 1, 16'h1357);
      go(0, 20'h40010, 1, 0);
      go(6, 20'h000FF, 0, 0);
      go(5, 20'h00000, 0, 0);
      done("narrow", 1'b0);
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         if (i == 20)
            done("random wide", 1'b1);
         go(seed[5:0] % 5, seed[27:8] & {19'h7FFFB, seed[5:0] % 5 != 4}, seed[6], seed[31:16]);
      end
      done("random narrow", 1'b0);
      final_report;
   end
   initial begin
      // Some sixty transfers of at most sixteen cycles, with wide margin
      #200000;
      cmp("watchdog", 0, 1);
      final_report;
   end
endmodule : bus_byte_lane_steering_tb
`default_nettype wire
